// ---- dv/dbgsr_host_model.sv ----
// host development system issuing debug register commands
`timescale 1ns/1ns
module dbgsr_host_model
  import dbgsr_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       cmdAccept,
  input  wire logic [7:0] readData,
  output dbgsr_req_t      hostReq
);
  initial hostReq = '0;
  // one byte per command, held through the taking edge
  task automatic xfer(input dbgsr_cmd_t k, input logic w, input logic [15:0] a,
                      input logic [7:0] wd, output logic [7:0] rdat, output logic acc);
    @(posedge ref_clk);
    #1 hostReq = '{1'b1, k, w, a, wd};
    #1 acc = cmdAccept;
    @(posedge ref_clk);
    #1 hostReq = '{1'b0, DBGSR_CMD_NONE, 1'b0, ~a, ~wd};
    rdat = readData;
  endtask
endmodule

// ---- dv/dbgsr_status_block_checker.sv ----
// port assertions of the debug status block
`timescale 1ns/1ns
module dbgsr_status_block_checker
  import dbgsr_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire dbgsr_req_t hostReq,
  input wire logic       fwStoreEnable,
  input wire logic       debugEntry,
  input wire logic       debugExit,
  input wire logic [7:0] userCcr,
  input wire logic       lowStrobeEnable,
  input wire logic       readValid,
  input wire logic       cmdAccept,
  input wire logic       activeOut,
  input wire logic       serialDisabled,
  input wire logic       tagLowPulse,
  input wire logic       clkSwOut,
  input wire logic       clkSwitchPending,
  input wire logic [7:0] ccrRestore
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [7:0] pendCnt_r;
  logic [7:0] pendCnt_nxt;
  logic       rdTaken;
  assign rdTaken = hostReq.valid && cmdAccept && !hostReq.write
                   && hostReq.kind inside {DBGSR_CMD_HW_RD, DBGSR_CMD_FW_RD};
  always_comb pendCnt_nxt = clkSwitchPending ? pendCnt_r + 8'h01 : 8'h00;
  always_ff @(posedge ref_clk) pendCnt_r <= reset ? 8'h00 : pendCnt_nxt;
  // ====================
  // assertions
  a_read_answer: assert property (rdTaken |=> readValid)
    else $error("read not answered");
  a_read_spurious: assert property (readValid |-> $past(rdTaken))
    else $error("read answer without read");
  a_tag_refuse: assert property (serialDisabled |-> !cmdAccept)
    else $error("command taken while tagging");
  a_accept_free: assert property (hostReq.valid && !serialDisabled |-> cmdAccept)
    else $error("command refused");
  a_tag_delay: assert property (hostReq.valid && cmdAccept && !activeOut
    && hostReq.kind == DBGSR_CMD_TAG_GO_CMD |=> !serialDisabled[*8] ##[7:9] serialDisabled)
    else $error("tag start delay wrong");
  a_tag_clear: assert property ($rose(activeOut) |-> ##[0:1] !serialDisabled)
    else $error("tagging kept on entry");
  a_active_set: assert property ($rose(activeOut) |-> $past(debugEntry))
    else $error("active set without entry");
  a_ccr_capture: assert property ($rose(activeOut) |-> ccrRestore == $past(userCcr))
    else $error("ccr not captured");
  a_active_clear: assert property ($fell(activeOut) |-> $past(debugExit || fwStoreEnable))
    else $error("active cleared without exit");
  a_ccr_write: assert property (hostReq.valid && cmdAccept && hostReq.write
    && hostReq.addr == 16'hff06 && !debugEntry |=> ccrRestore == $past(hostReq.data))
    else $error("ccr write lost");
  a_tag_pulse: assert property (tagLowPulse |-> serialDisabled && lowStrobeEnable)
    else $error("tag pulse outside tagging");
  a_pend_rise: assert property ($changed(clkSwOut) |-> ##[0:1] clkSwitchPending)
    else $error("clock switch not pending");
  a_pend_len: assert property ($fell(clkSwitchPending) |-> pendCnt_r == 8'h96)
    else $error("clock switch wait length wrong");
endmodule
bind dbgsr_status_block dbgsr_status_block_checker u_chk (.*);

// ---- dv/dbgsr_status_block_tb.sv ----
// self-checking bench of the debug status block
`timescale 1ns/1ns
`include "dbgsr_regs.svh"
module dbgsr_status_block_tb
  import dbgsr_pkg::*;
;
  logic ref_clk = 0, reset = 1, dataPhaseDone = 0, fwStoreEnable = 0, fwEnableSet = 0;
  logic debugEntry = 0, debugExit = 0, specialSingleChip = 0, secured = 0, fullyErased = 0;
  logic eraseVerifyDone = 0, unsecSet = 0, lowStrobeEnable = 0, lowByteTagInput = 1;
  logic externalBusClock = 0, instrFetchLow = 1, readValid, cmdAccept, activeOut, acc;
  logic serialDisabled, tagLowPulse, clkSwOut, clkSwitchPending, seen;
  logic [7:0]  userCcr = 8'h3c, readData, ccrRestore, d;
  logic [15:0] registerBlockInit = 16'h5000;
  dbgsr_req_t  hostReq;
  int          failures = 0, cmpCount = 0;
  dbgsr_status_block u_dut (.*);
  dbgsr_host_model u_host (.ref_clk(ref_clk), .cmdAccept(cmdAccept), .readData(readData),
                           .hostReq(hostReq));
  always #5 ref_clk = ~ref_clk;
  always begin
    repeat (4) @(posedge ref_clk);
    #1 externalBusClock = ~externalBusClock;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    u_host.xfer(DBGSR_CMD_HW_RD, 1'b0, a, 8'h00, d, acc);
    chk(d, e);
    chk({7'h0, readValid}, 8'h01);
  endtask
  task automatic wr(input dbgsr_cmd_t k, input logic [15:0] a, input logic [7:0] v);
    u_host.xfer(k, 1'b1, a, v, d, acc);
  endtask
  task automatic pulse(ref logic s);
    @(posedge ref_clk);
    #1 s = 1;
    @(posedge ref_clk);
    #1 s = 0;
  endtask
  task automatic wrap_up();
    $display("failures=%0d comparisons=%0d", failures, cmpCount);
    if (failures == 0 && cmpCount > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #50000;
    failures++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    #1 reset = 0;
    rd(`DBGSR_ADDR_STATUS, 8'h00);
    rd(`DBGSR_ADDR_CCR, 8'hd8);
    wr(DBGSR_CMD_HW_WR, `DBGSR_ADDR_POS, 8'hff);
    rd(`DBGSR_ADDR_POS, 8'h50);
    wr(DBGSR_CMD_HW_WR, 16'hff02, 8'hff);
    rd(16'hff02, 8'h00);
    rd(`DBGSR_ADDR_STATUS, 8'h00);
    wr(DBGSR_CMD_HW_WR, `DBGSR_ADDR_STATUS, 8'hc5);
    chk({7'h0, clkSwOut}, 8'h01);
    rd(`DBGSR_ADDR_STATUS, 8'h84);
    chk({7'h0, clkSwitchPending}, 8'h01);
    repeat (150) @(posedge ref_clk);
    #1 chk({7'h0, clkSwitchPending}, 8'h00);
    wr(DBGSR_CMD_HW_WR, `DBGSR_ADDR_CCR, 8'h5a);
    chk(ccrRestore, 8'h5a);
    rd(`DBGSR_ADDR_CCR, 8'h5a);
    pulse(debugEntry);
    chk({7'h0, activeOut}, 8'h01);
    rd(`DBGSR_ADDR_CCR, 8'h3c);
    fwStoreEnable = 1;
    wr(DBGSR_CMD_FW_WR, `DBGSR_ADDR_STATUS, 8'h84);
    fwStoreEnable = 0;
    chk({7'h0, activeOut}, 8'h00);
    wr(DBGSR_CMD_HW_WR, `DBGSR_ADDR_STATUS, 8'h00);
    pulse(debugEntry);
    chk({7'h0, activeOut}, 8'h00);
    wr(DBGSR_CMD_HW_WR, `DBGSR_ADDR_STATUS, 8'h80);
    pulse(debugEntry);
    pulse(debugExit);
    chk({7'h0, activeOut}, 8'h00);
    u_host.xfer(DBGSR_CMD_STEP, 1'b0, 16'h0000, 8'h00, d, acc);
    rd(`DBGSR_ADDR_STATUS, 8'h88);
    pulse(dataPhaseDone);
    rd(`DBGSR_ADDR_STATUS, 8'h90);
    rd(`DBGSR_ADDR_STATUS, 8'h80);
    u_host.xfer(DBGSR_CMD_TAG_GO_CMD, 1'b0, 16'h0000, 8'h00, d, acc);
    repeat (18) @(posedge ref_clk);
    #1 chk({7'h0, serialDisabled}, 8'h01);
    u_host.xfer(DBGSR_CMD_HW_RD, 1'b0, `DBGSR_ADDR_STATUS, 8'h00, d, acc);
    chk({7'h0, acc}, 8'h00);
    lowStrobeEnable = 1;
    lowByteTagInput = 0;
    seen = 0;
    repeat (40) begin
      @(posedge ref_clk);
      #2 seen = seen | tagLowPulse;
    end
    chk({7'h0, seen}, 8'h01);
    lowByteTagInput = 1;
    pulse(debugEntry);
    @(posedge ref_clk);
    rd(`DBGSR_ADDR_STATUS, 8'hc0);
    specialSingleChip = 1;
    fwEnableSet = 1;
    wr(DBGSR_CMD_HW_WR, `DBGSR_ADDR_STATUS, 8'h00);
    rd(`DBGSR_ADDR_STATUS, 8'hc0);
    secured = 1;
    fullyErased = 1;
    pulse(unsecSet);
    rd(`DBGSR_ADDR_STATUS, 8'hc2);
    fullyErased = 0;
    reset = 1;
    repeat (2) @(posedge ref_clk);
    #1 reset = 0;
    rd(`DBGSR_ADDR_STATUS, 8'h00);
    eraseVerifyDone = 1;
    rd(`DBGSR_ADDR_STATUS, 8'h80);
    wrap_up();
  end
endmodule

// ---- logic/dbgsr_pkg.sv ----
// types shared by the debug status block
package dbgsr_pkg;
  typedef enum logic [2:0] {
    DBGSR_CMD_NONE    = 3'b000,
    DBGSR_CMD_HW_RD   = 3'b001,
    DBGSR_CMD_HW_WR   = 3'b010,
    DBGSR_CMD_FW_RD   = 3'b011,
    DBGSR_CMD_FW_WR   = 3'b100,
    DBGSR_CMD_STEP    = 3'b101,
    DBGSR_CMD_TAG_GO_CMD   = 3'b110,
    DBGSR_CMD_OTHER   = 3'b111
  } dbgsr_cmd_t;

  typedef enum logic [1:0] {
    DBGSR_TAG_IDLE  = 2'b00,
    DBGSR_TAG_WAIT  = 2'b01,
    DBGSR_TAG_ON    = 2'b10
  } dbgsr_tag_t;

  typedef struct packed {
    logic       valid;
    dbgsr_cmd_t kind;
    logic       write;
    logic [15:0] addr;
    logic [7:0] data;
  } dbgsr_req_t;

  typedef struct packed {
    logic       enable;
    logic       active;
    logic       tagEn;
    logic       shift_data_valid_bit;
    logic       trace;
    logic       clock_switch_bit;
    logic       unsecure_bit;
  } dbgsr_flags_t;
endpackage

// ---- logic/dbgsr_regs.svh ----
// register offsets, bit positions, reset values and timing counts of the debug status block
`ifndef DBGSR_REGS_SVH
`define DBGSR_REGS_SVH
`define DBGSR_ADDR_STATUS 16'hff01
`define DBGSR_ADDR_CCR 16'hff06
`define DBGSR_ADDR_POS 16'hff07
`define DBGSR_BIT_ENABLE 7
`define DBGSR_BIT_ACTIVE 6
`define DBGSR_BIT_TAGEN 5
`define DBGSR_BIT_SDV 4
`define DBGSR_BIT_TRACE 3
`define DBGSR_BIT_CLOCK_SWITCH_BIT 2
`define DBGSR_BIT_UNSECURE_BIT 1
`define DBGSR_POS_LSB 11
`define DBGSR_POS_MSB 14
`define DBGSR_POS_SHIFT 8
`define DBGSR_ZERO8 8'h00
`define DBGSR_CCR_RESET 8'hd8
`define DBGSR_TAG_DELAY 5'h10
`define DBGSR_CLK_CYCLES_NS 1500
`define DBGSR_CLK_PERIOD_NS 10
`define DBGSR_CLK_DELAY ((`DBGSR_CLK_CYCLES_NS) / (`DBGSR_CLK_PERIOD_NS))
`endif

// ---- logic/dbgsr_status_block.sv ----
// debug status, condition-code holding and register-position shadow block
// Summary of operation
// - low tag pin low at bus clock fall tags
// - registers reached only by host debug commands
// - status ff01, ccr ff06 rw; shadow ff07 read
// - enable bit gates activation; hardware commands accepted except while tagging
// - firmware sets enable after reset, secured waits
// - unsecured special single-chip with firmware enable set reads enable as one
// - active bit set on entry, firmware exit clears
// - timed firmware store clears active, leaves debug
// - clock switch written only by debug writes
// - tag enable set by tag-go, cleared entry
// - sixteen cycles later serial off, tagging on
// - no serial commands processed while tagging
// - shift-data-valid set when data phase completes
// - shift-data-valid cleared on next command, exit
// - trace bit set by each single-step command, cleared by any other command except a status write, which loads it from bit 3
// - unsecure set only secured and erased, reads one only in special single-chip
// - status readable except while tagging, bit zero reads zero
// - shadow mirrors register block base bits
// - ccr captured on entry, writes modify it
// - new debug clock active within 150 cycles
`timescale 1ns/1ns
`include "dbgsr_regs.svh"
module dbgsr_status_block
  import dbgsr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire dbgsr_req_t  hostReq,
  input  wire logic        dataPhaseDone,
  input  wire logic        fwStoreEnable,
  input  wire logic        fwEnableSet,
  input  wire logic        debugEntry,
  input  wire logic        debugExit,
  input  wire logic [7:0]  userCcr,
  input  wire logic [15:0] registerBlockInit,
  input  wire logic        specialSingleChip,
  input  wire logic        secured,
  input  wire logic        fullyErased,
  input  wire logic        eraseVerifyDone,
  input  wire logic        unsecSet,
  input  wire logic        lowStrobeEnable,
  input  wire logic        lowByteTagInput,
  input  wire logic        externalBusClock,
  input  wire logic        instrFetchLow,
  output logic [7:0]       readData,
  output logic             readValid,
  output logic             cmdAccept,
  output logic             activeOut,
  output logic             serialDisabled,
  output logic             tagLowPulse,
  output logic             clkSwOut,
  output logic             clkSwitchPending,
  output logic [7:0]       ccrRestore
);
  // ===========================================================
  // pin synchronisers
  logic tagLevel, eclkFall;

  dbgsr_sync uTagSync (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .pinIn     (lowByteTagInput),
    .levelOut  (tagLevel),
    .fallPulse ()
  );

  dbgsr_sync uEclkSync (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .pinIn     (externalBusClock),
    .levelOut  (),
    .fallPulse (eclkFall)
  );

  // ===========================================================
  // decode functions
  function automatic logic isAddr(input logic [15:0] a, input logic [15:0] b);
    isAddr = (a == b);
  endfunction

  function automatic logic isCmd(input dbgsr_req_t r, input dbgsr_cmd_t k);
    isCmd = r.valid & (r.kind == k);
  endfunction

  function automatic logic isRead(input dbgsr_req_t r);
    isRead = ~r.write & ((r.kind == DBGSR_CMD_HW_RD) | (r.kind == DBGSR_CMD_FW_RD));
  endfunction

  function automatic logic isWrite(input dbgsr_req_t r);
    isWrite = r.write & ((r.kind == DBGSR_CMD_HW_WR) | (r.kind == DBGSR_CMD_FW_WR));
  endfunction

  // ===========================================================
  // state
  dbgsr_flags_t flags_r, flags_nxt;
  logic [7:0]   ccr_r, ccr_nxt;
  dbgsr_tag_t   tag_r, tag_nxt;
  logic [4:0]   tagCnt_r, tagCnt_nxt;
  logic [7:0]   clkCnt_r, clkCnt_nxt;
  logic [7:0]   rdData_r, rdData_nxt;
  logic         rdValid_r, rdValid_nxt;
  logic         tagPulse_r, tagPulse_nxt;
  logic         fwEnDone_r, fwEnDone_nxt;

  logic         reqOk;
  logic         hwWrite;
  logic         regWrite;
  logic         statusWr;
  logic         ccrWr;
  logic         fwClear;
  logic         fwEnGo;
  logic         entryGo;
  logic [7:0]   wd;
  logic [7:0]   statusRead;
  logic [7:0]   posRead;
  logic         enableRead;

  // ===========================================================
  // host request acceptance
  always_comb begin
    reqOk    = hostReq.valid & (tag_r != DBGSR_TAG_ON);
    hwWrite  = reqOk & (hostReq.kind == DBGSR_CMD_HW_WR);
    regWrite = reqOk & isWrite(hostReq);
    wd       = hostReq.data;
  end

  // ===========================================================
  // write and event decode
  always_comb begin
    statusWr = regWrite & isAddr(hostReq.addr, `DBGSR_ADDR_STATUS);
    ccrWr    = regWrite & isAddr(hostReq.addr, `DBGSR_ADDR_CCR);
    fwClear  = statusWr & ~hwWrite & fwStoreEnable & ~wd[`DBGSR_BIT_ACTIVE];
    fwEnGo   = fwEnableSet & ~fwEnDone_r & (~secured | eraseVerifyDone);
    entryGo  = debugEntry & flags_r.enable;
  end

  // ===========================================================
  // read values
  always_comb begin
    enableRead = flags_r.enable |
                 (specialSingleChip & (~secured | fullyErased) & fwEnableSet);
    statusRead = `DBGSR_ZERO8;
    statusRead[`DBGSR_BIT_ENABLE] = enableRead;
    statusRead[`DBGSR_BIT_ACTIVE] = flags_r.active;
    statusRead[`DBGSR_BIT_TAGEN]  = flags_r.tagEn & ~flags_r.active;
    statusRead[`DBGSR_BIT_SDV]    = flags_r.shift_data_valid_bit;
    statusRead[`DBGSR_BIT_TRACE]  = flags_r.trace;
    statusRead[`DBGSR_BIT_CLOCK_SWITCH_BIT]  = flags_r.clock_switch_bit;
    statusRead[`DBGSR_BIT_UNSECURE_BIT]  = specialSingleChip & flags_r.unsecure_bit;
    posRead = `DBGSR_ZERO8;
    posRead[`DBGSR_POS_MSB-`DBGSR_POS_SHIFT:`DBGSR_POS_LSB-`DBGSR_POS_SHIFT] =
      registerBlockInit[`DBGSR_POS_MSB:`DBGSR_POS_LSB];
  end

  // ===========================================================
  // status and ccr next state
  always_comb begin
    flags_nxt    = flags_r;
    ccr_nxt      = ccr_r;
    rdData_nxt   = rdData_r;
    rdValid_nxt  = 1'b0;
    fwEnDone_nxt = fwEnDone_r;
    // firmware enable after reset, secured waits for erase verify
    if (fwEnGo) begin
      flags_nxt.enable = 1'b1;
      fwEnDone_nxt     = 1'b1;
    end
    // command recognition
    if (reqOk) begin
      flags_nxt.shift_data_valid_bit   = 1'b0;
      flags_nxt.trace = (hostReq.kind == DBGSR_CMD_STEP);
      if (isCmd(hostReq, DBGSR_CMD_TAG_GO_CMD) & ~flags_r.active) begin
        flags_nxt.tagEn = 1'b1;
      end
      if (isRead(hostReq)) begin
        rdValid_nxt = 1'b1;
        if (isAddr(hostReq.addr, `DBGSR_ADDR_STATUS)) begin
          rdData_nxt = statusRead;
        end else if (isAddr(hostReq.addr, `DBGSR_ADDR_CCR)) begin
          rdData_nxt = ccr_r;
        end else if (isAddr(hostReq.addr, `DBGSR_ADDR_POS)) begin
          rdData_nxt = posRead;
        end else begin
          rdData_nxt = `DBGSR_ZERO8;
        end
      end
    end
    // register writes; reserved addresses fall through untouched
    if (statusWr) begin
      flags_nxt.enable = wd[`DBGSR_BIT_ENABLE];
      flags_nxt.tagEn  = wd[`DBGSR_BIT_TAGEN];
      flags_nxt.shift_data_valid_bit    = wd[`DBGSR_BIT_SDV];
      flags_nxt.trace  = wd[`DBGSR_BIT_TRACE];
      flags_nxt.clock_switch_bit  = wd[`DBGSR_BIT_CLOCK_SWITCH_BIT];
      if (fwClear) begin
        flags_nxt.active = 1'b0;
      end
    end else if (ccrWr) begin
      ccr_nxt = wd;
    end
    // firmware exit store also clears active
    if (debugExit) begin
      flags_nxt.active = 1'b0;
      flags_nxt.shift_data_valid_bit    = 1'b0;
    end
    if (dataPhaseDone) begin
      flags_nxt.shift_data_valid_bit = 1'b1;
    end
    if (unsecSet & specialSingleChip & secured & fullyErased) begin
      flags_nxt.unsecure_bit = 1'b1;
    end
    // entry only while enabled
    if (entryGo) begin
      flags_nxt.active = 1'b1;
      flags_nxt.tagEn  = 1'b0;
      ccr_nxt          = userCcr;
    end
  end

  // ===========================================================
  // tagging sequencer
  always_comb begin
    tag_nxt      = tag_r;
    tagCnt_nxt   = tagCnt_r;
    tagPulse_nxt = 1'b0;
    case (tag_r)
      DBGSR_TAG_IDLE: begin
        if (flags_nxt.tagEn & ~flags_r.tagEn) begin
          tag_nxt    = DBGSR_TAG_WAIT;
          tagCnt_nxt = `DBGSR_TAG_DELAY;
        end
      end
      DBGSR_TAG_WAIT: begin
        tagCnt_nxt = tagCnt_r - 5'h01;
        if (tagCnt_r == 5'h01) begin
          tag_nxt = DBGSR_TAG_ON;
        end
        if (~flags_r.tagEn) begin
          tag_nxt = DBGSR_TAG_IDLE;
        end
      end
      DBGSR_TAG_ON: begin
        tagPulse_nxt = eclkFall & ~tagLevel & lowStrobeEnable & instrFetchLow &
                       flags_r.tagEn & ~flags_r.active;
        if (~flags_r.tagEn | flags_r.active) begin
          tag_nxt = DBGSR_TAG_IDLE;
        end
      end
      default: begin
        tag_nxt = DBGSR_TAG_IDLE;
      end
    endcase
  end

  // ===========================================================
  // clock switch delay
  always_comb begin
    clkCnt_nxt = clkCnt_r;
    if (flags_nxt.clock_switch_bit != flags_r.clock_switch_bit) begin
      clkCnt_nxt = 8'(`DBGSR_CLK_DELAY);
    end else if (clkCnt_r != `DBGSR_ZERO8) begin
      clkCnt_nxt = clkCnt_r - 8'h01;
    end
  end

  // ===========================================================
  // registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flags_r    <= '0;
      ccr_r      <= `DBGSR_CCR_RESET;
      tag_r      <= DBGSR_TAG_IDLE;
      tagCnt_r   <= 5'h00;
      clkCnt_r   <= `DBGSR_ZERO8;
      rdData_r   <= `DBGSR_ZERO8;
      rdValid_r  <= 1'b0;
      tagPulse_r <= 1'b0;
      fwEnDone_r <= 1'b0;
    end else begin
      flags_r    <= flags_nxt;
      ccr_r      <= ccr_nxt;
      tag_r      <= tag_nxt;
      tagCnt_r   <= tagCnt_nxt;
      clkCnt_r   <= clkCnt_nxt;
      rdData_r   <= rdData_nxt;
      rdValid_r  <= rdValid_nxt;
      tagPulse_r <= tagPulse_nxt;
      fwEnDone_r <= fwEnDone_nxt;
    end
  end

  // ===========================================================
  // outputs
  assign readData         = rdData_r;
  assign readValid        = rdValid_r;
  assign cmdAccept        = reqOk;
  assign activeOut        = flags_r.active;
  assign serialDisabled   = (tag_r == DBGSR_TAG_ON);
  assign tagLowPulse      = tagPulse_r;
  assign clkSwOut         = flags_r.clock_switch_bit;
  assign clkSwitchPending = (clkCnt_r != `DBGSR_ZERO8);
  assign ccrRestore       = ccr_r;
endmodule

// ---- logic/dbgsr_sync.sv ----
// three-stage synchroniser for pin inputs
`timescale 1ns/1ns
module dbgsr_sync
  import dbgsr_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic pinIn,
  output logic      levelOut,
  output logic      fallPulse
);
  logic s1_r, s2_r, s3_r, lvl_r;
  logic s1_nxt, s2_nxt, s3_nxt, lvl_nxt, fall_nxt;
  logic fall_r;

  always_comb begin
    s1_nxt   = pinIn;
    s2_nxt   = s1_r;
    s3_nxt   = s2_r;
    lvl_nxt  = lvl_r;
    fall_nxt = 1'b0;
    if (s2_r == s3_r) begin
      lvl_nxt  = s3_r;
      fall_nxt = lvl_r & ~s3_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s1_r   <= 1'b1;
      s2_r   <= 1'b1;
      s3_r   <= 1'b1;
      lvl_r  <= 1'b1;
      fall_r <= 1'b0;
    end else begin
      s1_r   <= s1_nxt;
      s2_r   <= s2_nxt;
      s3_r   <= s3_nxt;
      lvl_r  <= lvl_nxt;
      fall_r <= fall_nxt;
    end
  end

  assign levelOut  = lvl_r;
  assign fallPulse = fall_r;
endmodule
